/* hdl/host_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.vh"
module host_port #(
    parameter AW = 32,
    parameter DW = 48
) (
    input wire clock_in,
    input wire resetn_in,
    input wire chip_select_n_in,
    input wire host_bus_request_n_in,
    input wire read_strobe_n_in,
    input wire store_strobe_n_in,
    input wire suspend_bus_three_state_n_in,
    input wire master_handover_cycle_in,
    input wire sync_cycle_in,
    input wire eprom_boot_in,
    input wire ready_active_drive_in,
    input wire [AW-1:0] host_address_in,
    input wire [DW-1:0] host_data_in,
    input wire [DW-1:0] mem_read_data_in,
    output wire host_bus_grant_n_out,
    output wire host_bus_grant_n_oe_out,
    output wire host_ready_out,
    output wire host_ready_oe_out,
    output wire mem_iface_oe_out,
    output wire boot_memory_select_n_oe_out,
    output wire [DW-1:0] host_data_out,
    output wire host_data_oe_out,
    output wire sync_handshake_oe_out,
    output wire mem_read_out,
    output wire mem_write_out,
    output wire [AW-1:0] mem_address_out,
    output wire [DW-1:0] mem_write_data_out
);
// --------------------------------
// input synchronisers
// --------------------------------
reg [4:0] sync1;
reg [4:0] sync2;
always @(posedge clock_in or negedge resetn_in)
begin
    if (!resetn_in)
    begin
        sync1 <= 5'h1f;
        sync2 <= 5'h1f;
    end
    else
    begin
        sync1 <= {chip_select_n_in, host_bus_request_n_in, read_strobe_n_in, store_strobe_n_in,
                  suspend_bus_three_state_n_in};
        sync2 <= sync1;
    end
end
wire cs_n = sync2[4];
wire hbr_n = sync2[3];
wire rd_n = sync2[2];
wire wr_n = sync2[1];
wire suspend_bus_three_state_n_n = sync2[0];
wire host_req = !cs_n && !hbr_n;
// --------------------------------
// handover and access sequencer
// --------------------------------
reg [2:0] state;
reg [2:0] next_state;
reg [7:0] count;
reg [7:0] next_count;
reg grant_n;
reg iface_oe;
reg ready_low;
reg [DW-1:0] data_q;
reg data_oe;
reg mem_rd;
reg mem_wr;
reg [AW-1:0] addr_q;
reg [DW-1:0] wdata_q;
// counts kept at the counter's width so a load never drops bits
localparam [7:0] READ_LEN = `READY_READ_CYCLES;
localparam [7:0] WRITE_LEN = `READY_WRITE_CYCLES;
localparam [7:0] REDRIVE_LEN = `REDRIVE_CYCLES;
// --------------------------------
// shared decode
// --------------------------------
// last cycle of a counted phase; sequencer and datapath must agree on it
function count_done;
    input [7:0] value;
    begin
        count_done = (value <= 8'h01);
    end
endfunction
// --------------------------------
// next state
// --------------------------------
always @*
begin
    next_state = state;
    next_count = count;
    case (state)
        `ST_IDLE:
            if (host_req)
                next_state = `ST_RELEASE;
        `ST_RELEASE:
            next_state = `ST_GRANTED;
        `ST_GRANTED:
            if (!host_req)
                next_state = `ST_RETURN;
            else if (!rd_n)
            begin
                next_state = `ST_READ;
                next_count = READ_LEN;
            end
            else if (!wr_n)
            begin
                next_state = `ST_WRITE;
                next_count = WRITE_LEN;
            end
        `ST_READ, `ST_WRITE:
            if (!count_done(count))
                next_count = count - 8'h01;
            else
                next_state = `ST_DONE;
        `ST_DONE:
            if (rd_n && wr_n)
                next_state = `ST_GRANTED;
        `ST_RETURN:
            if (!count_done(count))
                next_count = count - 8'h01;
            else
                next_state = `ST_IDLE;
        default:
            next_state = `ST_IDLE;
    endcase
    if (state == `ST_GRANTED && !host_req)
        next_count = REDRIVE_LEN;
end
// --------------------------------
// handover registers
// --------------------------------
always @(posedge clock_in or negedge resetn_in)
begin
    if (!resetn_in)
    begin
        state <= `ST_IDLE;
        count <= 8'h00;
        grant_n <= 1'b1;
        iface_oe <= 1'b1;
        ready_low <= 1'b0;
    end
    else
    begin
        state <= next_state;
        count <= next_count;
        // interface off one cycle before grant falls
        if (state == `ST_IDLE && host_req)
            iface_oe <= 1'b0;
        if (state == `ST_RELEASE)
            grant_n <= 1'b0;
        if (state == `ST_GRANTED && !host_req)
            grant_n <= 1'b1;
        // the host may still be driving for a while after grant rises
        if (state == `ST_RETURN && count_done(count))
            iface_oe <= 1'b1;
        // ready held low from request until grant, then again for the read or write phase
        ready_low <= (host_req && (next_state == `ST_IDLE || next_state == `ST_RELEASE)) ||
                     next_state == `ST_READ || next_state == `ST_WRITE;
    end
end
// --------------------------------
// memory access path
// --------------------------------
// read data is refreshed every read cycle, the last time on the same edge that ready rises
always @(posedge clock_in or negedge resetn_in)
begin
    if (!resetn_in)
    begin
        data_q <= {DW{1'b0}};
        data_oe <= 1'b0;
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        addr_q <= {AW{1'b0}};
        wdata_q <= {DW{1'b0}};
    end
    else
    begin
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        if (state == `ST_GRANTED && !rd_n && host_req)
        begin
            addr_q <= host_address_in;
            mem_rd <= 1'b1;
        end
        if (state == `ST_READ)
        begin
            data_q <= mem_read_data_in;
            data_oe <= 1'b1;
        end
        if (state == `ST_DONE && rd_n)
            data_oe <= 1'b0;
        // write commits late so the host's address and data have long settled
        if (state == `ST_WRITE && count_done(count))
        begin
            addr_q <= host_address_in;
            wdata_q <= host_data_in;
            mem_wr <= 1'b1;
        end
    end
end
// --------------------------------
// pin drive
// --------------------------------
wire released = !iface_oe || !suspend_bus_three_state_n_n || master_handover_cycle_in;
assign mem_iface_oe_out = !released;
assign boot_memory_select_n_oe_out = !released && eprom_boot_in;
assign host_bus_grant_n_out = grant_n;
assign host_bus_grant_n_oe_out = 1'b1;
assign host_ready_out = !ready_low;
// open drain drives only the low level; active drive also drives high
assign host_ready_oe_out = ready_low || ready_active_drive_in;
assign host_data_out = data_q;
assign host_data_oe_out = data_oe || (sync_cycle_in && !released);
assign sync_handshake_oe_out = sync_cycle_in && !released;
assign mem_read_out = mem_rd;
assign mem_write_out = mem_wr;
assign mem_address_out = addr_q;
assign mem_write_data_out = wdata_q;
endmodule
`default_nettype wire

/* hdl/host_port_defs.vh */
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH
`define CLK_PERIOD_NS 25
// read ready low pulse: 45 ns + one period, rounded up
`define READY_READ_NS 45
`define READY_READ_CYCLES ((`READY_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define READY_WRITE_NS 15
`define READY_WRITE_CYCLES ((`READY_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// enable after grant high: 19 ns + one period
`define REDRIVE_NS 19
`define REDRIVE_CYCLES ((`REDRIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define ST_IDLE 3'h0
`define ST_RELEASE 3'h1
`define ST_GRANTED 3'h2
`define ST_READ 3'h3
`define ST_WRITE 3'h4
`define ST_DONE 3'h5
`define ST_RETURN 3'h6
`endif

/* verif/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock_in,
    input wire logic host_bus_grant_n_out,
    input wire logic host_ready_out,
    output var logic chip_select_n_in = 1'b1,
    output var logic host_bus_request_n_in = 1'b1,
    output var logic read_strobe_n_in = 1'b1,
    output var logic store_strobe_n_in = 1'b1
);
    task automatic access(input logic wr);
        int n;
        chip_select_n_in <= 1'b0;
        host_bus_request_n_in <= 1'b0;
        for (n = 0; n < 40 && host_bus_grant_n_out !== 1'b0; n++) @(posedge clock_in);
        @(posedge clock_in);
        if (wr) store_strobe_n_in <= 1'b0; else read_strobe_n_in <= 1'b0;
        // pins are synchronised, so ready seen before then is stale
        repeat (4) @(posedge clock_in);
        for (n = 0; n < 40 && host_ready_out !== 1'b1; n++) @(posedge clock_in);
        read_strobe_n_in <= 1'b1;
        store_strobe_n_in <= 1'b1;
        @(posedge clock_in);
        chip_select_n_in <= 1'b1;
        host_bus_request_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
    endtask
endmodule
`default_nettype wire

/* verif/host_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_monitor (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic chip_select_n_in,
    input wire logic host_bus_request_n_in,
    input wire logic read_strobe_n_in,
    input wire logic suspend_bus_three_state_n_in,
    input wire logic master_handover_cycle_in,
    input wire logic host_bus_grant_n_out,
    input wire logic host_ready_out,
    input wire logic mem_iface_oe_out,
    input wire logic host_data_oe_out,
    input wire logic mem_read_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    a_grant_release: assert property ($fell(host_bus_grant_n_out) |-> !mem_iface_oe_out)
        else $error("grant with iface on");
    a_redrive_late: assert property (mem_iface_oe_out |-> host_bus_grant_n_out)
        else $error("iface on while granted");
    a_data_first: assert property ($rose(host_ready_out) && !read_strobe_n_in |-> host_data_oe_out)
        else $error("ready before data");
    a_ready_hold: assert property ($fell(chip_select_n_in | host_bus_request_n_in) |-> ##[1:4] !host_ready_out)
        else $error("ready not pulled low");
    a_grant_held: assert property (!(host_bus_grant_n_out | host_bus_request_n_in | chip_select_n_in)
        |=> !host_bus_grant_n_out) else $error("grant dropped");
    a_suspend_off: assert property (!suspend_bus_three_state_n_in [*4] |-> !mem_iface_oe_out)
        else $error("iface on in suspend");
    a_master_off: assert property (master_handover_cycle_in |-> !mem_iface_oe_out)
        else $error("iface on in handover");
    a_read_taken: assert property ($fell(read_strobe_n_in) && !host_bus_grant_n_out |-> ##[1:6] mem_read_out)
        else $error("read not taken");
endmodule
bind host_port host_port_monitor mon (.*);
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_in = 1'b0, resetn_in = 1'b0, eprom_boot_in = 1'b0, sync_cycle_in = 1'b0;
    logic suspend_bus_three_state_n_in = 1'b1, master_handover_cycle_in = 1'b0, ready_active_drive_in = 1'b1;
    logic rdy_q = 1'b1;
    logic [31:0] host_address_in = 32'h0;
    logic [47:0] host_data_in = 48'h0, mem_read_data_in = 48'h0;
    logic [63:0] r;
    wire chip_select_n_in, host_bus_request_n_in, read_strobe_n_in, store_strobe_n_in, host_bus_grant_n_out;
    wire host_bus_grant_n_oe_out, host_ready_out, host_ready_oe_out, mem_iface_oe_out, boot_memory_select_n_oe_out;
    wire host_data_oe_out, sync_handshake_oe_out, mem_read_out, mem_write_out;
    wire [47:0] host_data_out, mem_write_data_out;
    wire [31:0] mem_address_out;
    logic [79:0] exp_q[$];
    int miscompares = 0, cmp_count = 0;
    host_port dut (.*);
    host_model host (.*);
    initial forever #12.5 clock_in = ~clock_in;
    task check(input logic [79:0] got, input logic [79:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d, wrong %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // results return in request order, so one queue pairs them
    always @(posedge clock_in)
    begin
        rdy_q <= host_ready_out;
        if (mem_write_out)
            check({mem_address_out, mem_write_data_out}, exp_q.pop_front());
        if (host_ready_out && !rdy_q && host_data_oe_out)
            check({32'h0, host_data_out}, exp_q.pop_front());
        if (mem_read_out)
            check({48'h0, mem_address_out}, {48'h0, host_address_in});
        check({79'h0, host_ready_oe_out}, {79'h0, !host_ready_out || ready_active_drive_in});
    end
    initial
    begin
        void'($urandom(32'h5418));
        repeat (5) @(posedge clock_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            r = {$urandom, $urandom};
            host_address_in <= {1'b1, r[30:0]};
            host_data_in <= r[63:16];
            mem_read_data_in <= r[47:0];
            eprom_boot_in <= r[5];
            ready_active_drive_in <= r[9];
            exp_q.push_back(r[7] ? {1'b1, r[30:0], r[63:16]} : {32'h0, r[47:0]});
            host.access(r[7]);
        end
        $display("access test done");
        suspend_bus_three_state_n_in <= 1'b0;
        eprom_boot_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        check({78'h0, mem_iface_oe_out, boot_memory_select_n_oe_out}, 80'h0);
        suspend_bus_three_state_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        check({77'h0, mem_iface_oe_out, boot_memory_select_n_oe_out, host_bus_grant_n_oe_out}, 80'h7);
        master_handover_cycle_in <= 1'b1;
        sync_cycle_in <= 1'b1;
        @(posedge clock_in);
        check({78'h0, mem_iface_oe_out, sync_handshake_oe_out}, 80'h0);
        master_handover_cycle_in <= 1'b0;
        @(posedge clock_in);
        check({78'h0, sync_handshake_oe_out, host_data_oe_out}, 80'h3);
        sync_cycle_in <= 1'b0;
        $display("release test done");
        close_out;
    end
    initial
    begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule
`default_nettype wire
